//--- bridge_fault_pkg.sv
// Shared constants and types for the bridge control and fault protection block
`default_nettype none
package bridge_fault_pkg;
  // ----------------------------------------------------------------
  // Register map (word offsets in bytes)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CONTROL = 8'h00;  // Control register
  localparam logic [7:0] ADDR_COMMAND = 8'h04;  // Command register (clear faults)
  localparam logic [7:0] ADDR_STATUS  = 8'h08;  // Latched fault status
  localparam logic [7:0] ADDR_STATE   = 8'h0C;  // Live state readback

  // Control field positions
  localparam int CTL_SLEW_LSB = 0;   // Slew select, 3 bits
  localparam int CTL_OCP_LSB  = 3;   // Overcurrent policy, 2 bits
  localparam int CTL_MODE_LSB = 5;   // Bridge mode, 2 bits
  localparam int CTL_PUMP_BIT = 7;   // Pump check off
  localparam int CTL_STRAP_BIT = 8;  // Use strap pin for slew
  localparam int CMD_CLEAR_BIT = 0;  // Clear faults bit

  // Status field positions
  localparam int ST_FAULT = 0;
  localparam int ST_UV    = 1;
  localparam int ST_PUMP  = 2;
  localparam int ST_OC    = 3;
  localparam int ST_OC_FET_LSB = 4;  // Four per-transistor flags

  localparam logic [8:0] CONTROL_RESET = 9'h000;

  // ----------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] OCP_LATCH  = 2'h0;
  localparam logic [1:0] OCP_RETRY  = 2'h1;
  localparam logic [1:0] OCP_REPORT = 2'h2;
  localparam logic [1:0] OCP_OFF    = 2'h3;
  localparam logic [1:0] MODE_INDEP = 2'h2;
  localparam logic [2:0] SLEW_FASTEST = 3'h0;  // 53.2 V/us
  localparam logic [2:0] SLEW_MID     = 3'h3;  // 13 V/us
  localparam logic [2:0] SLEW_SLOWEST = 3'h7;  // 2.6 V/us

  // Strap pin states
  localparam logic [1:0] STRAP_GND  = 2'h0;
  localparam logic [1:0] STRAP_OPEN = 2'h1;
  localparam logic [1:0] STRAP_HIGH = 2'h2;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 200;
  localparam int DELAY_FAST_NS = 1500;  // Input to output delay, fastest slew
  localparam int DELAY_SLOW_NS = 4500;  // Input to output delay, slowest slew
  localparam int DELAY_FAST_CYC = DELAY_FAST_NS * CLK_MHZ / 1000;
  localparam int DELAY_SLOW_CYC = DELAY_SLOW_NS * CLK_MHZ / 1000;
  localparam int DELAY_STEP_CYC = (DELAY_SLOW_CYC - DELAY_FAST_CYC) / 7;
  localparam int CORE_READY_CYC = 16;   // Wake-up time of the core
  localparam int CNT_W = 16;

  // Half-bridge phase
  typedef enum logic [2:0] {
    HB_OFF  = 3'b001,
    HB_DEAD = 3'b010,
    HB_ON   = 3'b100
  } hb_state_e;

  // Gate drive of one half bridge
  typedef struct packed {
    logic high;
    logic low;
  } gate_s;

  // Analogue comparator inputs
  typedef struct packed {
    logic       supply_uv;
    logic       pump_uv;
    logic [3:0] over_current;  // HS1, LS1, HS2, LS2
  } sense_s;
endpackage
`default_nettype wire

//--- bridge_fault_protection.sv
// Bridge control, slew decode, dead time and fault protection with Wishbone registers
//
// What this block does
// - Decode three-bit slew field into eight rates
// - Strap pin: ground, open, high pick rates
// - Dead time between transistors, scaled by slew
// - Deglitch inputs; delay 1.5 to 4.5 us
// - Turn off conducting transistor before switching
// - Fault indicator low while any fault
// - Indicator low until core is ready
// - Sleep while sleep input low
// - No serial output while sleep held low
// - Supply undervoltage: all off, pump off, latch
// - Undervoltage flag held until cleared
// - Pump undervoltage: outputs off, skip if disabled
// - Pump flag held until cleared
// - Overcurrent after filter time, pump stays on
// - Independent mode: per half bridge handling
// - Policy 00: latch off until cleared
// - Policy 01: retry after wait
// - Policy 10: report only, keep driving
// - Policy 11: no action at all
`default_nettype none
module bridge_fault_protection
  import bridge_fault_pkg::*;
#(
  parameter int OCP_FILTER_CYC = 600,   // Overcurrent filter time
  parameter int RETRY_CYC      = 4000,  // Retry wait
  parameter int DEAD_BASE_CYC  = 40     // Dead time at fastest slew
) (
  // Clock and reset
  input  wire logic                     core_clk_i,
  input  wire logic                     rstn_i,
  // Wishbone slave
  input  wire logic                     wb_cyc_i,
  input  wire logic                     wb_stb_i,
  input  wire logic                     wb_we_i,
  input  wire logic [7:0]               wb_adr_i,
  input  wire logic [3:0]               wb_sel_i,
  input  wire logic [31:0]              wb_dat_i,
  output logic      [31:0]              wb_dat_o,
  output logic                          wb_ack_o,
  // Pins
  input  wire logic                     sleep_input_n_i,
  input  wire logic [1:0]               bridge_control_input_i,
  input  wire logic [1:0]               slew_strap_i,
  input  wire bridge_fault_pkg::sense_s sense_i,
  output bridge_fault_pkg::gate_s [1:0] gate_o,
  output logic                          pump_enable_o,
  output logic                          fault_indicator_n_o,
  output logic                          fault_indicator_oe_o,
  output logic                          serial_out_allow_o,
  output logic      [2:0]               slew_select_o
);
  import bridge_fault_pkg::*;

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  sense_s     sense_m, sense_s2;        // Sense sync stages
  logic [1:0] in_m, in_s;               // Control input stages
  logic [1:0] strap_m, strap_s;         // Strap stages
  logic       sleep_m, sleep_s;         // Sleep stages

  // Two flops on every pin
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sense_m  <= '0;
      sense_s2 <= '0;
      in_m     <= 2'h0;
      in_s     <= 2'h0;
      strap_m  <= 2'h0;
      strap_s  <= 2'h0;
      sleep_m  <= 1'b0;
      sleep_s  <= 1'b0;
    end else begin
      sense_m  <= sense_i;
      sense_s2 <= sense_m;
      in_m     <= bridge_control_input_i;
      in_s     <= in_m;
      strap_m  <= slew_strap_i;
      strap_s  <= strap_m;
      sleep_m  <= sleep_input_n_i;
      sleep_s  <= sleep_m;
    end
  end

  // ----------------------------------------------------------------
  // Sleep and core ready
  // ----------------------------------------------------------------
  logic             sleep_prev;   // Previous sleep level
  logic             clear_pulse;  // Sleep reset pulse ended
  logic [CNT_W-1:0] ready_cnt;    // Wake-up counter
  logic             core_ready;   // Core is functional

  // Wake counter restarts on every sleep
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ready_cnt  <= '0;
      core_ready <= 1'b0;
    end else if (!sleep_s) begin
      ready_cnt  <= '0;
      core_ready <= 1'b0;
    end else if (ready_cnt == CNT_W'(CORE_READY_CYC)) begin
      core_ready <= 1'b1;
    end else begin
      ready_cnt <= ready_cnt + 1'b1;
    end
  end

  // Edge memory of sleep level
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sleep_prev <= 1'b0;
    end else begin
      sleep_prev <= sleep_s;
    end
  end
  assign clear_pulse = sleep_s && !sleep_prev;  // Wake edge clears faults

  // No serial drive while asleep
  assign serial_out_allow_o = sleep_s;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [8:0] control;      // Control register
  logic       clear_cmd;    // Clear faults command pulse
  logic       wb_hit;       // Request awaiting answer
  logic [7:0] status;       // Latched status
  logic       clear_all;    // Any clear source

  assign wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;
  // Either the clear command or the wake edge clears
  assign clear_all = clear_cmd || clear_pulse;

  // Control writes, byte lanes 0 and 1
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      control <= CONTROL_RESET;
    end else if (wb_hit && wb_we_i && wb_adr_i == ADDR_CONTROL) begin
      if (wb_sel_i[0]) control[7:0] <= wb_dat_i[7:0];
      if (wb_sel_i[1]) control[8]   <= wb_dat_i[8];
    end
  end

  // Clear bit is self-clearing
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      clear_cmd <= 1'b0;
    end else begin
      clear_cmd <= wb_hit && wb_we_i && wb_sel_i[0] && wb_adr_i == ADDR_COMMAND
                   && wb_dat_i[CMD_CLEAR_BIT];
    end
  end

  // Ack one cycle after the request, read data registered
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_hit;
      if (wb_hit && !wb_we_i) begin
        case (wb_adr_i)
          ADDR_CONTROL: wb_dat_o <= {23'h0, control};
          ADDR_STATUS:  wb_dat_o <= {24'h0, status};
          ADDR_STATE:   wb_dat_o <= {26'h0, core_ready, pump_enable_o, gate_o};
          default:      wb_dat_o <= 32'h0000_0000;  // Unmapped and command
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Slew selection
  // ----------------------------------------------------------------
  logic [2:0] strap_slew;  // Slew from strap pin

  // Strap decode
  always_comb begin
    case (strap_s)
      STRAP_GND:  strap_slew = SLEW_FASTEST;
      STRAP_OPEN: strap_slew = SLEW_MID;
      STRAP_HIGH: strap_slew = SLEW_SLOWEST;
      default:    strap_slew = SLEW_MID;
    endcase
  end

  // Register field or strap picks the rate code
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      slew_select_o <= SLEW_FASTEST;
    end else begin
      slew_select_o <= control[CTL_STRAP_BIT] ? strap_slew
                                              : control[CTL_SLEW_LSB +: 3];
    end
  end

  // Delay figures per slew step
  logic [CNT_W-1:0] glitch_cyc;  // Deglitch length
  logic [CNT_W-1:0] dead_cyc;    // Dead interval length
  assign glitch_cyc = CNT_W'(DELAY_FAST_CYC) + CNT_W'(DELAY_STEP_CYC) * CNT_W'(slew_select_o);
  assign dead_cyc   = CNT_W'(DEAD_BASE_CYC) * (CNT_W'(slew_select_o) + CNT_W'(1));

  // ----------------------------------------------------------------
  // Fault detection
  // ----------------------------------------------------------------
  logic [1:0] ocp_mode;             // Overcurrent policy
  logic       indep;                // Independent half-bridge mode
  logic       pump_uv;              // Pump fault after check-off gate
  logic [3:0] oc_event;             // Filtered overcurrent per transistor
  logic [1:0] oc_shut;              // Per half bridge shutdown
  logic [1:0] oc_hold;              // Overcurrent latch per half bridge
  logic [CNT_W-1:0] retry_cnt [2];  // Retry timers

  assign ocp_mode = control[CTL_OCP_LSB +: 2];
  assign indep    = control[CTL_MODE_LSB +: 2] == MODE_INDEP;
  assign pump_uv  = sense_s2.pump_uv && !control[CTL_PUMP_BIT];

  // Overcurrent filter per transistor
  for (genvar f = 0; f < 4; f++) begin : g_filt
    logic [CNT_W-1:0] oc_cnt;  // Time above limit
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
        oc_cnt <= '0;
      end else if (!sense_s2.over_current[f]) begin
        oc_cnt <= '0;
      end else if (oc_cnt != CNT_W'(OCP_FILTER_CYC)) begin
        oc_cnt <= oc_cnt + 1'b1;
      end
    end
    assign oc_event[f] = oc_cnt == CNT_W'(OCP_FILTER_CYC) && ocp_mode != OCP_OFF;
  end

  // Policy state per half bridge
  for (genvar h = 0; h < 2; h++) begin : g_pol
    logic hit;     // Event on this half bridge, or any in joint mode
    logic active;  // Condition still present
    assign hit    = indep ? |oc_event[2*h +: 2] : |oc_event;
    assign active = indep ? |sense_s2.over_current[2*h +: 2] : |sense_s2.over_current;
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
        oc_hold[h]   <= 1'b0;
        retry_cnt[h] <= '0;
      end else if (hit) begin
        oc_hold[h]   <= 1'b1;  // Set wins over clear
        retry_cnt[h] <= '0;
      end else if (oc_hold[h]) begin
        case (ocp_mode)
          OCP_RETRY: begin
            if (retry_cnt[h] != CNT_W'(RETRY_CYC)) retry_cnt[h] <= retry_cnt[h] + 1'b1;
            else if (!active) oc_hold[h] <= 1'b0;
          end
          OCP_OFF: oc_hold[h] <= 1'b0;
          default: if (clear_all && !active) oc_hold[h] <= 1'b0;
        endcase
      end
    end
    // Report-only keeps driving
    assign oc_shut[h] = oc_hold[h] && (ocp_mode == OCP_LATCH || ocp_mode == OCP_RETRY);
  end

  // Latched status flags, set wins over clear
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      status <= 8'h00;
    end else begin
      status[ST_UV]   <= sense_s2.supply_uv || (status[ST_UV] && !clear_all);
      status[ST_PUMP] <= pump_uv || (status[ST_PUMP] && !clear_all);
      status[ST_OC]   <= |oc_event || (status[ST_OC] && !clear_all);
      status[ST_OC_FET_LSB +: 4] <= oc_event | (status[ST_OC_FET_LSB +: 4] & {4{!clear_all}});
      status[ST_FAULT] <= sense_s2.supply_uv || pump_uv || |oc_event
                          || (status[ST_FAULT] && !clear_all);
    end
  end

  // Pump off only on supply undervoltage or sleep
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) pump_enable_o <= 1'b0;
    else         pump_enable_o <= sleep_s && !sense_s2.supply_uv;
  end

  // Indicator: faults or core not ready
  logic fault_now;
  assign fault_now = sense_s2.supply_uv || pump_uv || |oc_hold || !core_ready;
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      fault_indicator_oe_o <= 1'b1;
    end else begin
      fault_indicator_oe_o <= fault_now;
    end
  end
  assign fault_indicator_n_o = 1'b0;  // Open drain: only ever pulls low

  // ----------------------------------------------------------------
  // Half-bridge drivers
  // ----------------------------------------------------------------
  logic drive_ok;  // Global permission to drive
  assign drive_ok = core_ready && !sense_s2.supply_uv && !pump_uv;

  for (genvar b = 0; b < 2; b++) begin : g_hb
    logic [CNT_W-1:0] glitch_cnt;  // Stable-input timer
    logic             filt;        // Deglitched input
    logic             want;        // Level being driven
    logic [CNT_W-1:0] dead_cnt;    // Dead interval timer
    hb_state_e        st;          // Phase

    // Deglitch: input must hold steady
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
        glitch_cnt <= '0;
        filt       <= 1'b0;
      end else if (in_s[b] == filt) begin
        glitch_cnt <= '0;
      end else if (glitch_cnt >= glitch_cyc) begin
        filt       <= in_s[b];
        glitch_cnt <= '0;
      end else begin
        glitch_cnt <= glitch_cnt + 1'b1;
      end
    end

    // Off, then dead interval, then the other transistor
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
        st       <= HB_OFF;
        want     <= 1'b0;
        dead_cnt <= '0;
      end else if (!drive_ok || oc_shut[b]) begin
        st <= HB_OFF;
      end else begin
        case (st)
          HB_OFF: begin
            want     <= filt;
            dead_cnt <= '0;
            st       <= HB_DEAD;
          end
          HB_DEAD: begin
            if (dead_cnt >= dead_cyc) st <= HB_ON;
            else dead_cnt <= dead_cnt + 1'b1;
          end
          HB_ON: if (filt != want) st <= HB_OFF;
          default: st <= HB_OFF;
        endcase
      end
    end

    // Gates registered from phase
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
        gate_o[b] <= '0;
      end else begin
        gate_o[b].high <= st == HB_ON && want && drive_ok && !oc_shut[b];
        gate_o[b].low  <= st == HB_ON && !want && drive_ok && !oc_shut[b];
      end
    end
  end
endmodule
`default_nettype wire

//--- bridge_fault_protection_props.sv
// Port-level assertions for the bridge fault protection block
`default_nettype none
module bridge_fault_protection_props (
  // Clock and reset
  input wire logic                          core_clk_i,
  input wire logic                          rstn_i,
  // Bus handshake
  input wire logic                          wb_cyc_i,
  input wire logic                          wb_stb_i,
  input wire logic                          wb_ack_o,
  // Pins
  input wire logic                          sleep_input_n_i,
  input wire bridge_fault_pkg::sense_s      sense_i,
  input wire bridge_fault_pkg::gate_s [1:0] gate_o,
  input wire logic                          pump_enable_o,
  input wire logic                          fault_indicator_n_o,
  input wire logic                          fault_indicator_oe_o,
  input wire logic                          serial_out_allow_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import bridge_fault_pkg::*;
  // ----------------------------------------------------------------
  // Clocking
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  // Bus answers one cycle after a request, for one cycle only
  a_ack_follows: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus request not answered in one cycle");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  // Never both transistors of a half bridge on
  a_no_shoot: assert property (!(gate_o[0].high && gate_o[0].low) && !(gate_o[1].high && gate_o[1].low))
    else $error("both transistors of a half bridge on");
  // High side off leaves the output floating before the low side comes on
  a_dead_gap: assert property ($fell(gate_o[0].high) |-> !gate_o[0].low [*3])
    else $error("dead interval missing");
  // Supply undervoltage shuts gates, pump and flags the pin
  a_uv_gates_off: assert property (sense_i.supply_uv [*3] |-> ##2 gate_o == 4'h0)
    else $error("gates on during supply undervoltage");
  a_uv_pump_off: assert property (sense_i.supply_uv [*3] |-> ##1 !pump_enable_o)
    else $error("pump on during supply undervoltage");
  a_uv_indicator: assert property (sense_i.supply_uv [*3] |-> ##2 fault_indicator_oe_o)
    else $error("fault pin released during undervoltage");
  // Open drain pin only ever pulls low
  a_od_low: assert property (fault_indicator_n_o == 1'b0)
    else $error("fault pin driven high");
  // Serial output forbidden while asleep
  a_sleep_quiet: assert property (!sleep_input_n_i [*3] |-> !serial_out_allow_o)
    else $error("serial output allowed in sleep");
  // Pin held low while the core wakes
  a_wake_reset: assert property ($rose(rstn_i) |-> fault_indicator_oe_o [*8])
    else $error("fault pin released too early after reset");
  a_wake_sleep: assert property ($rose(sleep_input_n_i) |-> fault_indicator_oe_o [*4])
    else $error("fault pin released too early after sleep");
  // Main scenarios reached
  c_uv: cover property (sense_i.supply_uv ##1 gate_o == 4'h0);
  c_dead: cover property ($fell(gate_o[0].high));
  c_wake: cover property (!sleep_input_n_i ##1 sleep_input_n_i);
endmodule
bind bridge_fault_protection bridge_fault_protection_props u_props (
  .core_clk_i(core_clk_i), .rstn_i(rstn_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .sleep_input_n_i(sleep_input_n_i), .sense_i(sense_i),
  .gate_o(gate_o), .pump_enable_o(pump_enable_o), .fault_indicator_n_o(fault_indicator_n_o),
  .fault_indicator_oe_o(fault_indicator_oe_o), .serial_out_allow_o(serial_out_allow_o)
);
`default_nettype wire

//--- host_pins.sv
// Host pin model: sleep line and bridge control inputs
`default_nettype none
module host_pins (
  // Clock
  input  wire logic       core_clk_i,
  // Requests from the bench
  input  wire logic       want_sleep_i,
  input  wire logic [1:0] want_drive_i,
  // Pins toward the block
  output var logic        sleep_input_n_o = 1'b1,
  output var logic [1:0]  bridge_control_input_o = 2'h0
);
  timeunit 1ns;
  timeprecision 1ps;
  // Sleep pulled low only on request; faults normally cleared over the bus
  always @(posedge core_clk_i) begin
    sleep_input_n_o <= !want_sleep_i;
  end
  // Control inputs move just after an edge, then stand still
  always @(posedge core_clk_i) begin
    bridge_control_input_o <= want_drive_i;
  end
endmodule
`default_nettype wire

//--- test_bridge_fault_protection.sv
// Self-checking bench for the bridge fault protection block
`default_nettype none
`define CHK(got, want) \
  begin \
    compares++; \
    if ((got) !== (want)) begin \
      mismatches++; \
      $display("unexpected at %0t: got %h want %h", $time, (got), (want)); \
    end \
  end
module test_bridge_fault_protection;
  timeunit 1ns;
  timeprecision 1ps;
  import bridge_fault_pkg::*;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  localparam int FILT  = 4;   // Shortened overcurrent filter
  localparam int RETRY = 20;  // Shortened retry wait
  logic        core_clk_i = 1'b0, rstn_i = 1'b0;
  logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [3:0]  wb_sel_i = 4'hF;  // Full words only
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
  logic        want_sleep = 1'b0, sleep_n;
  logic [1:0]  want_drive = 2'h0, drive, slew_strap_i = 2'h0;
  sense_s      sense_i = '0;
  gate_s [1:0] gate_o;
  logic        pump_enable_o, fault_indicator_n_o, fault_indicator_oe_o, serial_out_allow_o;
  logic [2:0]  slew_select_o;
  logic [15:0] lfsr = 16'h002B;  // Random source, fixed start
  logic [2:0]  strap_exp [4] = '{SLEW_FASTEST, SLEW_MID, SLEW_SLOWEST, SLEW_MID};
  int          mismatches = 0, compares = 0, cycles = 0, d0, d7, p;
  // ----------------------------------------------------------------
  // Instances
  // ----------------------------------------------------------------
  host_pins u_host_pins (.core_clk_i(core_clk_i), .want_sleep_i(want_sleep),
    .want_drive_i(want_drive), .sleep_input_n_o(sleep_n), .bridge_control_input_o(drive));
  bridge_fault_protection #(.OCP_FILTER_CYC(FILT), .RETRY_CYC(RETRY), .DEAD_BASE_CYC(2))
  u_bridge_fault_protection (.core_clk_i(core_clk_i), .rstn_i(rstn_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .sleep_input_n_i(sleep_n),
    .bridge_control_input_i(drive), .slew_strap_i(slew_strap_i), .sense_i(sense_i),
    .gate_o(gate_o), .pump_enable_o(pump_enable_o), .fault_indicator_n_o(fault_indicator_n_o),
    .fault_indicator_oe_o(fault_indicator_oe_o), .serial_out_allow_o(serial_out_allow_o),
    .slew_select_o(slew_select_o));
  // ----------------------------------------------------------------
  // Clock, timeout and helpers
  // ----------------------------------------------------------------
  always #2.5 core_clk_i = ~core_clk_i;
  // Hang guard
  always @(posedge core_clk_i) begin
    cycles++;
    if (cycles == 40000) begin
      mismatches++;
      close_out();
    end
  end
  task automatic close_out();
    if (mismatches == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk_i);
  endtask
  // Classic single Wishbone cycle; read data lands in rd
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    // Wait for the answer; ack ends this wait, else only the hang guard
    do begin
      @(posedge core_clk_i);
    end while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge core_clk_i);
  endtask
  function automatic logic [15:0] lfsr_next(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  // Expected gates: 1 drives high side, 0 low side
  function automatic logic [3:0] gexp(input logic [1:0] in);
    return {in[1], ~in[1], in[0], ~in[0]};
  endfunction
  // Cycles from an input edge to the high side coming on
  task automatic measure(output int d);
    want_drive <= 2'b01;
    d = 0;
    do begin
      @(posedge core_clk_i);
      d++;
    end while (gate_o[0].high !== 1'b1 && d < 3000);
    want_drive <= 2'b00;
    tick(2000);
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    tick(10);
    rstn_i <= 1'b1;
    tick(40);
    `CHK(fault_indicator_oe_o, 1'b0)
    wb(0, ADDR_STATE, 0);
    `CHK(rd[5], 1'b1)
    wb(0, ADDR_CONTROL, 0);
    `CHK(rd, 32'(CONTROL_RESET))
    for (int s = 0; s < 8; s++) begin
      wb(1, ADDR_CONTROL, s);
      tick(2);
      `CHK(slew_select_o, 3'(s))
    end
    for (int k = 0; k < 4; k++) begin
      slew_strap_i <= 2'(k);
      wb(1, ADDR_CONTROL, 32'h100);
      tick(4);
      `CHK(slew_select_o, strap_exp[k])
    end
    wb(1, ADDR_CONTROL, 0);
    measure(d0);
    `CHK(d0 >= DELAY_FAST_CYC && d0 <= DELAY_FAST_CYC + 30, 1'b1)
    wb(1, ADDR_CONTROL, 7);
    measure(d7);
    `CHK(d7 >= DELAY_SLOW_CYC && d7 <= DELAY_SLOW_CYC + 40, 1'b1)
    `CHK(d7 > d0, 1'b1)
    wb(1, ADDR_CONTROL, 0);
    for (int i = 0; i < 12; i++) begin
      lfsr = lfsr_next(lfsr);
      want_drive <= lfsr[1:0];
      wb(0, {lfsr[9:4], 2'h3}, 0);
      `CHK(rd, 32'h0)
      tick(400);
      `CHK(gate_o, gexp(lfsr[1:0]))
    end
    want_drive <= 2'b11;
    tick(400);
    sense_i.supply_uv <= 1'b1;
    tick(10);
    `CHK({gate_o, pump_enable_o, fault_indicator_oe_o}, 6'b000001)
    sense_i.supply_uv <= 1'b0;
    tick(40);
    `CHK(gate_o, 4'hA)
    wb(0, ADDR_STATUS, 0);
    `CHK(rd, 32'h3)
    want_sleep <= 1'b1;
    tick(10);
    `CHK({gate_o, serial_out_allow_o}, 5'h00)
    want_sleep <= 1'b0;
    tick(6);
    `CHK(fault_indicator_oe_o, 1'b1)
    tick(40);
    wb(0, ADDR_STATUS, 0);
    `CHK(rd, 32'h0)
    wb(1, ADDR_CONTROL, 32'h80);
    sense_i.pump_uv <= 1'b1;
    tick(10);
    `CHK(gate_o, 4'hA)
    sense_i.pump_uv <= 1'b0;
    wb(1, ADDR_CONTROL, 0);
    sense_i.pump_uv <= 1'b1;
    tick(10);
    `CHK({gate_o, pump_enable_o, fault_indicator_oe_o}, 6'b000011)
    sense_i.pump_uv <= 1'b0;
    tick(40);
    wb(0, ADDR_STATUS, 0);
    `CHK(rd, 32'h5)
    wb(1, ADDR_COMMAND, 1);
    wb(0, ADDR_STATUS, 0);
    `CHK(rd, 32'h0)
    sense_i.over_current <= 4'hF;
    tick(2);
    sense_i.over_current <= 4'h0;
    tick(20);
    wb(0, ADDR_STATUS, 0);
    `CHK(rd, 32'h0)
    for (p = 0; p < 4; p++) begin
      wb(1, ADDR_CONTROL, p << CTL_OCP_LSB);
      sense_i.over_current <= 4'hF;
      tick(FILT + 12);
      `CHK(gate_o, (p < 2) ? 4'h0 : 4'hA)
      `CHK(pump_enable_o, 1'b1)
      sense_i.over_current <= 4'h0;
      tick(RETRY + 40);
      `CHK(fault_indicator_oe_o, p == 0 || p == 2)
      `CHK(gate_o, (p == 0) ? 4'h0 : 4'hA)
      wb(0, ADDR_STATUS, 0);
      `CHK(rd, (p < 3) ? 32'hF9 : 32'h0)
      wb(1, ADDR_COMMAND, 1);
      tick(10);
      `CHK({gate_o, fault_indicator_oe_o}, 5'h14)
    end
    wb(1, ADDR_CONTROL, 32'(MODE_INDEP) << CTL_MODE_LSB);
    sense_i.over_current <= 4'hC;
    tick(FILT + 12);
    `CHK(gate_o, 4'h2)
    close_out();
  end
endmodule
`default_nettype wire
